// file: cic_top.v
// CPU interrupt controller with APB register access
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "cic_regs.vh"

module cic_top (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error
  input wire pin_group0_request, // Pin group 0 event
  input wire timer0_overflow_flag, // Timer 0 event
  input wire pin_group1_request, // Pin group 1 event
  input wire timer1_overflow_flag, // Timer 1 event
  input wire timer2_flag, // Timer 2 level
  input wire uart2_tx_rx_flags, // UART2/LIN level
  input wire i2c_master_event, // I2C master event
  input wire pwm_fault_request, // PWM/HV fault level
  input wire supply_thermal_request, // Supply level
  input wire converter_request, // Converter level
  input wire watchdog_flag, // Watchdog level
  input wire source6_request, // Source 6 level
  input wire spi_ecc_request, // SPI/ECC level
  input wire timers345_request, // Timers 3/4/5 level
  output reg irq_req, // Request to core
  output reg [15:0] irq_vector, // Vector address
  input wire irq_ack, // Core enters service
  input wire irq_return // Core returns
);

  reg [7:0] ie_q;
  reg [7:0] ip_q;
  reg [7:0] irq_enable_extended_q;
  reg [7:0] irq_priority_extended_q;
  reg vbase_q;
  reg [14:0] req_q;
  reg pin0_f_q;
  reg pin1_f_q;
  reg t0_f_q;
  reg t1_f_q;
  reg i2c_f_q;
  reg high_act_q;
  reg low_act_q;
  reg [3:0] sel_idx_q;
  reg sel_hi_q;
  wire [15:1] en;
  wire [15:1] pr;
  wire [15:1] pend;
  wire wr_en;
  wire rd_setup;
  wire mapped;
  wire take;
  reg [3:0] best_idx;
  reg best_hi;
  reg best_ok;
  integer i;

  // Register strobes, winner helpers and read bytes
  wire wr_ctrl;
  wire wr_pflag;
  wire wr_xflag;
  wire wr_ie;
  wire wr_ip;
  wire wr_irq_enable_extended;
  wire wr_irq_priority_extended;
  wire [15:1] cand_hi;
  wire [15:1] cand_lo;
  wire irq_req_d;
  wire [15:0] vec_d;
  wire [7:0] status_byte;
  wire [7:0] pflag_byte;
  wire [7:0] xflag_byte;
  genvar g;

  // Byte-address decode used by the error path only
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `CIC_OFF_CTRL: is_mapped = 1'b1;
        `CIC_OFF_STATUS: is_mapped = 1'b1;
        `CIC_OFF_XFLAG: is_mapped = 1'b1;
        `CIC_OFF_PFLAG: is_mapped = 1'b1;
        `CIC_OFF_IE: is_mapped = 1'b1;
        `CIC_OFF_IP: is_mapped = 1'b1;
        `CIC_OFF_IRQ_ENABLE_EXTENDED: is_mapped = 1'b1;
        `CIC_OFF_IRQ_PRIORITY_EXTENDED: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Write strobe for one register offset
  function wr_hit;
    input we;
    input [7:0] a;
    input [7:0] off;
    begin
      wr_hit = we & (a == off);
    end
  endfunction

  // Vector address of a slot: 8 bytes per natural priority step
  function [15:0] vec_of;
    input [3:0] idx;
    input base;
    reg [15:0] off;
    begin
      off = `CIC_VEC_FIRST + {9'h000, idx - 4'd1, 3'b000};
      vec_of = (base ? `CIC_VEC_HIGH : `CIC_VEC_LOW) | off;
    end
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = is_mapped(paddr);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign take = irq_ack & irq_req;

  // One write strobe per writable register
  assign wr_ctrl = wr_hit(wr_en, paddr, `CIC_OFF_CTRL);
  assign wr_pflag = wr_hit(wr_en, paddr, `CIC_OFF_PFLAG);
  assign wr_xflag = wr_hit(wr_en, paddr, `CIC_OFF_XFLAG);
  assign wr_ie = wr_hit(wr_en, paddr, `CIC_OFF_IE);
  assign wr_ip = wr_hit(wr_en, paddr, `CIC_OFF_IP);
  assign wr_irq_enable_extended = wr_hit(wr_en, paddr, `CIC_OFF_IRQ_ENABLE_EXTENDED);
  assign wr_irq_priority_extended = wr_hit(wr_en, paddr, `CIC_OFF_IRQ_PRIORITY_EXTENDED);

  // Request sampling on the rising edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 15'h0000;
    end else begin
      req_q <= {timers345_request, spi_ecc_request, source6_request,
                watchdog_flag, converter_request,
                supply_thermal_request, pwm_fault_request,
                i2c_master_event, uart2_tx_rx_flags, timer2_flag,
                timer1_overflow_flag, pin_group1_request,
                timer0_overflow_flag, pin_group0_request,
                1'b0};
    end
  end

  // Pin group 0 flag: set wins over a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin0_f_q <= 1'b0;
    end else if (req_q[1]) begin
      pin0_f_q <= 1'b1;
    end else if (wr_pflag && pwdata[`CIC_PF_PIN0]) begin
      pin0_f_q <= 1'b0;
    end
  end

  // Pin group 1 flag, cleared by software
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_f_q <= 1'b0;
    end else if (req_q[3]) begin
      pin1_f_q <= 1'b1;
    end else if (wr_pflag && pwdata[`CIC_PF_PIN1]) begin
      pin1_f_q <= 1'b0;
    end
  end

  // Timer 0 flag, cleared when its vector is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_f_q <= 1'b0;
    end else if (req_q[2]) begin
      t0_f_q <= 1'b1;
    end else if (take && sel_idx_q == `CIC_IDX_T0) begin
      t0_f_q <= 1'b0;
    end
  end

  // Timer 1 flag, cleared when its vector is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1_f_q <= 1'b0;
    end else if (req_q[4]) begin
      t1_f_q <= 1'b1;
    end else if (take && sel_idx_q == `CIC_IDX_T1) begin
      t1_f_q <= 1'b0;
    end
  end

  // I2C master flag, the only writable extended flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_f_q <= 1'b0;
    end else if (req_q[7]) begin
      i2c_f_q <= 1'b1;
    end else if (wr_xflag && pwdata[`CIC_XF_I2C]) begin
      i2c_f_q <= 1'b0;
    end
  end

  // Pending vector by natural priority slot; slot 5 has no source
  assign pend = {req_q[14:8], i2c_f_q, req_q[6:5], 1'b0,
                 t1_f_q, pin1_f_q, t0_f_q,
                 pin0_f_q};
  assign en = {irq_enable_extended_q, ie_q[6:5], 1'b0, ie_q[3:0]} &
              {15{ie_q[`CIC_IE_GLOBAL]}};
  assign pr = {irq_priority_extended_q, ip_q[6:5], 1'b0, ip_q[3:0]};

  // Qualified request per slot, split by level
  generate
    for (g = 1; g <= `CIC_NSRC; g = g + 1) begin : g_cand
      assign cand_hi[g] = pend[g] & en[g] & pr[g];
      assign cand_lo[g] = pend[g] & en[g] & ~pr[g];
    end
  endgenerate

  // Winner search: first high-level slot, else first low-level slot
  always @* begin
    best_idx = 4'd0;
    best_hi = 1'b0;
    best_ok = 1'b0;
    for (i = `CIC_NSRC; i >= 1; i = i - 1) begin
      if (cand_lo[i]) begin
        best_idx = i[3:0];
        best_ok = 1'b1;
      end
    end
    for (i = `CIC_NSRC; i >= 1; i = i - 1) begin
      if (cand_hi[i]) begin
        best_idx = i[3:0];
        best_hi = 1'b1;
        best_ok = 1'b1;
      end
    end
  end

  // High service blocks all; low service blocks low winners
  assign irq_req_d = best_ok && !high_act_q &&
                     (best_hi || !low_act_q);
  assign vec_d = vec_of(best_idx, vbase_q);

  // Request presented to the core, with nesting check
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector <= `CIC_VEC_LOW;
      sel_idx_q <= 4'd0;
      sel_hi_q <= 1'b0;
    end else if (take) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= irq_req_d;
      irq_vector <= vec_d;
      sel_idx_q <= best_idx;
      sel_hi_q <= best_hi;
    end
  end

  // Service-in-progress tracking
  // A return closes the innermost service, high before low, unless a take comes in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_act_q <= 1'b0;
      low_act_q <= 1'b0;
    end else if (take) begin
      if (sel_hi_q) begin
        high_act_q <= 1'b1;
      end else begin
        low_act_q <= 1'b1;
      end
    end else if (irq_return) begin
      if (high_act_q) begin
        high_act_q <= 1'b0;
      end else begin
        low_act_q <= 1'b0;
      end
    end
  end

  // Primary enable; the unused bit always reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= `CIC_RST_BYTE;
    end else if (wr_ie) begin
      ie_q <= pwdata[7:0] & 8'hef;
    end
  end

  // Primary priority; top bit reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ip_q <= `CIC_RST_BYTE;
    end else if (wr_ip) begin
      ip_q <= pwdata[7:0] & 8'h7f;
    end
  end

  // Extended enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_extended_q <= `CIC_RST_BYTE;
    end else if (wr_irq_enable_extended) begin
      irq_enable_extended_q <= pwdata[7:0];
    end
  end

  // Extended priority
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_priority_extended_q <= `CIC_RST_BYTE;
    end else if (wr_irq_priority_extended) begin
      irq_priority_extended_q <= pwdata[7:0];
    end
  end

  // Vector base select
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbase_q <= 1'b0;
    end else if (wr_ctrl) begin
      vbase_q <= pwdata[`CIC_CTRL_VBASE];
    end
  end

  // Read bytes of the status and flag registers
  assign status_byte = {1'b0, high_act_q, low_act_q,
                        5'h00};
  assign xflag_byte = {req_q[14:12], 1'b0,
                       req_q[10:8], i2c_f_q};
  assign pflag_byte = {t1_f_q, 1'b0, t0_f_q, 1'b0,
                       pin1_f_q, 1'b0, pin0_f_q, 1'b0};

  // Read data captured in the setup cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `CIC_OFF_CTRL: begin
          prdata <= {31'h00000000, vbase_q};
        end
        `CIC_OFF_STATUS: begin
          prdata <= {24'h000000, status_byte};
        end
        `CIC_OFF_XFLAG: begin
          prdata <= {24'h000000, xflag_byte};
        end
        `CIC_OFF_PFLAG: begin
          prdata <= {24'h000000, pflag_byte};
        end
        `CIC_OFF_IE: begin
          prdata <= {24'h000000, ie_q};
        end
        `CIC_OFF_IP: begin
          prdata <= {24'h000000, ip_q};
        end
        `CIC_OFF_IRQ_ENABLE_EXTENDED: begin
          prdata <= {24'h000000, irq_enable_extended_q};
        end
        `CIC_OFF_IRQ_PRIORITY_EXTENDED: begin
          prdata <= {24'h000000, irq_priority_extended_q};
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // cic_top

// file: cic_regs.vh
// Register map and constants of the CPU interrupt controller
// Overview of operation
// - Fourteen sources, each high or low level
// - Request lines sampled on rising clock edge
// - Vector core to highest pending enabled request
// - Base select 1 puts vectors at 0x7000
// - High level first; lower natural number wins
// - Software writes only clear request flags
// - Pin group 0: offset 0x0003, priority 1
// - Timer 0: offset 0x000B, hardware-cleared flag
// - Pin group 1: offset 0x0013, priority 3
// - Timer 1: offset 0x001B, hardware-cleared flag
// - Timer 2: offset 0x002B, priority 6
// - UART2/LIN: offset 0x0033, priority 7
// - I2C master: offset 0x003B, priority 8
// - PWM/HV fault: offset 0x0043, priority 9
// - Supply/thermal: offset 0x004B, priority 10
// - Converter done: offset 0x0053, priority 11
// - Watchdog: offset 0x005B, priority 12
// - SPI/ECC: offset 0x006B, priority 14
// - Timers 3/4/5: offset 0x0073, priority 15
// - Primary enable layout; global plus own bit
// - Extended enable layout; enables reset zero
// - Priority bit 1 means high level
// - Status shows high/low service in progress
// - Extended flags mirror; only I2C writable
`ifndef CIC_REGS_VH
`define CIC_REGS_VH

`define CIC_OFF_CTRL 8'h00
`define CIC_OFF_STATUS 8'h04
`define CIC_OFF_XFLAG 8'h08
`define CIC_OFF_PFLAG 8'h0c
`define CIC_OFF_IE 8'ha8
`define CIC_OFF_IP 8'hb8
`define CIC_OFF_IRQ_ENABLE_EXTENDED 8'he8
`define CIC_OFF_IRQ_PRIORITY_EXTENDED 8'hf8

`define CIC_RST_BYTE 8'h00

`define CIC_IE_GLOBAL 7
`define CIC_CTRL_VBASE 0
`define CIC_ST_HIGH 6
`define CIC_ST_LOW 5
`define CIC_PF_T1 7
`define CIC_PF_T0 5
`define CIC_PF_PIN1 3
`define CIC_PF_PIN0 1
`define CIC_XF_I2C 0

`define CIC_VEC_LOW 16'h0000
`define CIC_VEC_HIGH 16'h7000
`define CIC_VEC_FIRST 16'h0003
`define CIC_NSRC 15
`define CIC_IDX_T0 4'd2
`define CIC_IDX_T1 4'd4

`endif

// file: cic_checker.sv
// Port checker for the CPU interrupt controller
`timescale 1ns/100ps
module cic_checker (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Write
  input wire [7:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire pready, // Ready
  input wire [31:0] prdata, // Read data
  input wire pslverr, // Error
  input wire irq_req, // Request
  input wire [15:0] irq_vector, // Vector
  input wire irq_ack // Acknowledge
);
  logic ea_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ea_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == 8'ha8)
      ea_q <= pwdata[7];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ea_low2;
    !ea_q [*2];
  endsequence
  vec_form_a: assert property (
    irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector[11:7] == 5'h0)
    else $error("vector form");
  vec_base_a: assert property (
    irq_req |-> irq_vector[15:12] == 4'h0 || irq_vector[15:12] == 4'h7)
    else $error("vector base");
  ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request held after ack");
  glob_off_a: assert property (ea_low2 |-> !irq_req)
    else $error("request without global enable");
  read_width_a: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits");
  unmapped_a: assert property (
    psel && penable && paddr == 8'h10 |-> pslverr)
    else $error("unmapped not refused");
  ready_a: assert property (psel && penable |-> pready)
    else $error("no ready");
  prdata_hold_a: assert property (
    !psel || penable || pwrite |=> $stable(prdata))
    else $error("read data moved");
endmodule // cic_checker

// file: cic_core_model.sv
// Core sequencer model: takes each vector, returns after a delay
`timescale 1ns/100ps
module cic_core_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic irq_req, // Request
  input wire logic [15:0] irq_vector, // Vector
  output logic irq_ack, // Enter service
  output logic irq_return // Leave service
);
  logic [15:0] log_q [0:15];
  int n;
  int busy;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      n <= 0;
      busy <= 0;
    end else begin
      irq_ack <= irq_req && !irq_ack;
      irq_return <= busy == 1;
      busy <= busy - (busy != 0);
      if (irq_req && irq_ack) begin
        log_q[n[3:0]] <= irq_vector;
        n <= n + 1;
        busy <= 8;
      end
    end
  end
endmodule // cic_core_model

// file: tb_top.sv
// Self-checking bench for the CPU interrupt controller
`timescale 1ns/100ps
module tb_top;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [4:0] ev = 0;
  logic [6:0] lv = 0;
  logic [1:0] lv2 = 0;
  logic [15:0] ev_exp;
  logic err_q = 0;
  wire pready, pslverr, irq_req, irq_ack, irq_return;
  wire [31:0] prdata;
  wire [15:0] irq_vector;
  int fail_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  cic_top cic_top_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_group0_request(ev[0]), .timer0_overflow_flag(ev[1]),
    .pin_group1_request(ev[2]), .timer1_overflow_flag(ev[3]),
    .i2c_master_event(ev[4]), .timer2_flag(lv2[0]),
    .uart2_tx_rx_flags(lv2[1]),
    .pwm_fault_request(lv[0]), .supply_thermal_request(lv[1]),
    .converter_request(lv[2]), .watchdog_flag(lv[3]),
    .source6_request(lv[4]), .spi_ecc_request(lv[5]),
    .timers345_request(lv[6]), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .irq_return(irq_return));
  cic_core_model cic_core_model_i (.clk(clk), .rst_n(rst_n),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .irq_return(irq_return));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h0;
  endtask
  // Waits for the core model to take one more vector
  task automatic wait_irq(input logic [15:0] e);
    int n0;
    int k;
    n0 = cic_core_model_i.n;
    k = 0;
    while (cic_core_model_i.n == n0 && k < 60) begin
      @(posedge clk);
      k++;
    end
    if (cic_core_model_i.n == n0) begin
      fail_count++;
      results();
    end
    chk({16'h0, cic_core_model_i.log_q[n0[3:0]]}, {16'h0, e});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'ha8, 32'h0);
    rd(8'he8, 32'h0);
    rd(8'hf8, 32'h0);
    wr(8'hb8, 32'hff);
    rd(8'hb8, 32'h7f);
    wr(8'ha8, 32'hff);
    rd(8'ha8, 32'hef);
    wr(8'ha8, 32'h0);
    rd(8'h10, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    pulse(5'h10);
    rd(8'h08, 32'h1);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h0);
    lv <= 7'h20;
    wr(8'h08, 32'hfe);
    rd(8'h08, 32'h40);
    lv <= 7'h0;
    wr(8'ha8, 32'h82);
    pulse(5'h02);
    wait_irq(16'h000b);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h40);
    repeat (12) @(posedge clk);
    rd(8'h04, 32'h0);
    wr(8'ha8, 32'h8d);
    wr(8'hb8, 32'h08);
    pulse(5'h0d);
    wait_irq(16'h001b);
    wait_irq(16'h0003);
    wr(8'h0c, 32'h02);
    wait_irq(16'h0013);
    wr(8'h0c, 32'h08);
    repeat (12) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, {31'h0, i[0]});
      wr(8'he8, 32'h2 << i);
      lv[i] <= 1'b1;
      ev_exp = {i[0] ? 4'h7 : 4'h0, 12'h043 + 12'(8 * i)};
      wait_irq(ev_exp);
      lv <= 7'h0;
      repeat (12) @(posedge clk);
    end
    wr(8'ha8, 32'he0);
    wr(8'hb8, 32'h40);
    lv2 <= 2'h3;
    wait_irq(16'h0033);
    lv2 <= 2'h1;
    wait_irq(16'h002b);
    lv2 <= 2'h0;
    repeat (12) @(posedge clk);
    results();
  end
endmodule // tb_top
bind cic_top cic_checker chk_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_ack(irq_ack));
